/* File: rtl/two_level_interrupt_priority.sv */
`timescale 1ns/1ps
`include "intc_defines.svh"
module two_level_interrupt_priority (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_write,
    input wire logic sfr_read,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [14:0] basic_pending,
    input wire logic [14:0] basic_enable,
    input wire logic [15:0] upper_level_select,
    input wire logic converter_done_pending,
    input wire logic [3:0] soft_pending,
    input wire logic crystal_valid_flag,
    input wire logic flash_busy,
    input wire logic instr_done,
    input wire logic reti_done,
    input wire logic irq_ack,
    output logic irq_request,
    output intc_pkg::vector_type irq_vector,
    output logic irq_high_level,
    output logic low_in_service,
    output logic high_in_service
);
    import intc_pkg::*;

    logic [7:0] level_select_q;
    logic [7:0] source_enable_two_q;
    logic [7:0] rdata_q;
    source_vec_type requests;
    source_vec_type high_level;
    logic arb_valid;
    order_type arb_order;
    logic arb_high;
    logic winner_valid_q;
    logic winner_high_q;
    logic low_active_q;
    logic high_active_q;
    dispatch_state_type state_q;
    dispatch_state_type state_d;
    logic may_preempt;
    vector_type vector_q;
    logic level_select_wr;
    logic enable_two_wr;
    logic dispatch_open;

    // vector address is base plus eight bytes per order number
    function automatic vector_type order_to_vector(input order_type ord);
        return `VECTOR_BASE + (vector_type'(ord) << `VECTOR_STRIDE_SHIFT);
    endfunction

    // write decode; unmapped addresses are simply ignored
    assign level_select_wr = sfr_write && (sfr_addr == `LEVEL_SELECT_ADDR);
    assign enable_two_wr = sfr_write && (sfr_addr == `SOURCE_ENABLE_TWO_ADDR);

    // level select; bits 7:6 forced to zero so they always read zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            level_select_q <= `LEVEL_SELECT_RESET;
        end else if (level_select_wr) begin
            level_select_q <= sfr_wdata & `LEVEL_SELECT_MASK;
        end
    end

    // enable two; bit6 and bit0 dropped whatever software writes there
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            source_enable_two_q <= `SOURCE_ENABLE_TWO_RESET;
        end else if (enable_two_wr) begin
            source_enable_two_q <= sfr_wdata & `SOURCE_ENABLE_TWO_MASK;
        end
    end

    // registered read port, one cycle after the read strobe
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (sfr_read) begin
            case (sfr_addr)
                `LEVEL_SELECT_ADDR: rdata_q <= level_select_q;
                `SOURCE_ENABLE_TWO_ADDR: rdata_q <= source_enable_two_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign sfr_rdata = rdata_q;

    // gate each pending flag with its enable
    always_comb begin
        requests = '0;
        requests[14:0] = basic_pending & basic_enable;
        requests[`ORDER_CONVERTER] = converter_done_pending
            & source_enable_two_q[`EN_CONVERTER_BIT];
        for (int i = 0; i < 4; i++) begin
            requests[`ORDER_SOFT0 + i] = soft_pending[i]
                & source_enable_two_q[`EN_SOFT0_BIT + i];
        end
        // order 20 has no source; its slot stays empty so it can never win
        requests[`ORDER_UNUSED] = 1'b0;
        requests[`ORDER_CRYSTAL] = crystal_valid_flag
            & source_enable_two_q[`EN_CRYSTAL_BIT];
    end

    // basic six from the level register, the rest from outside
    always_comb begin
        high_level = '0;
        high_level[`NUM_BASIC_LEVELS-1:0] = level_select_q[`NUM_BASIC_LEVELS-1:0];
        high_level[`NUM_SOURCES-1:`NUM_BASIC_LEVELS] = upper_level_select;
    end

    // ranking is pure logic; its result is registered in the detect stage below
    level_arbiter arbiter (
        .requests(requests),
        .high_level(high_level),
        .winner_valid(arb_valid),
        .winner_order(arb_order),
        .winner_high(arb_high)
    );

    // detect stage: winner captured every cycle, costing one cycle of latency
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            winner_valid_q <= 1'b0;
            winner_high_q <= 1'b0;
            vector_q <= 16'h0000;
        end else begin
            winner_valid_q <= arb_valid;
            winner_high_q <= arb_high;
            vector_q <= order_to_vector(arb_order);
        end
    end

    // level in service; return clears the most recent, which is high if set
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            low_active_q <= 1'b0;
            high_active_q <= 1'b0;
        end else begin
            if (reti_done) begin
                if (high_active_q) begin
                    high_active_q <= 1'b0;
                end else begin
                    low_active_q <= 1'b0;
                end
            end else if (irq_ack && irq_request) begin
                // the call is taken: the captured winner's level enters service
                if (winner_high_q) begin
                    high_active_q <= 1'b1;
                end else begin
                    low_active_q <= 1'b1;
                end
            end
        end
    end

    // dispatch gating: return hold and flash stall
    always_comb begin
        state_d = state_q;
        case (state_q)
            st_run: begin
                if (flash_busy) begin
                    state_d = st_flash_stall;
                end else if (reti_done) begin
                    state_d = st_after_return;
                end
            end
            st_after_return: begin
                // one whole instruction must retire before the next call
                if (flash_busy) begin
                    state_d = st_flash_stall;
                end else if (reti_done) begin
                    // a further return restarts the wait instead of counting as the instruction
                    state_d = st_after_return;
                end else if (instr_done) begin
                    state_d = st_run;
                end
            end
            st_flash_stall: begin
                if (!flash_busy && reti_done) begin
                    // a return in the first free cycle still owes one instruction
                    state_d = st_after_return;
                end else if (!flash_busy) begin
                    state_d = st_run;
                end
            end
            default: state_d = st_run;
        endcase
    end

    // dispatch state register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= st_run;
        end else begin
            state_q <= state_d;
        end
    end

    // high may enter over low; nothing enters over high or an equal level
    always_comb begin
        if (winner_high_q) begin
            may_preempt = !high_active_q;
        end else begin
            may_preempt = !high_active_q && !low_active_q;
        end
    end

    // flash_busy also checked directly so a stall blocks in its first cycle,
    // and the return cycle is closed before the hold state is entered
    assign dispatch_open = (state_q == st_run) && !flash_busy && !reti_done;

    // the only combinational output; vector and level come straight from flops
    assign irq_request = winner_valid_q && may_preempt && dispatch_open;
    assign irq_vector = vector_q;
    assign irq_high_level = winner_high_q;
    assign low_in_service = low_active_q;
    assign high_in_service = high_active_q;
endmodule

/* File: rtl/intc_defines.svh */
// Summary of operation
// - each source is low or high; high preempts low, high is never preempted.
// - reset clears the level-select and enable-two register bits to zero; upper level selects and basic enables are inputs.
// - simultaneous requests: high level first, then smaller order number wins.
// - requests sampled and decoded every cycle; one detect cycle before the call.
// - pending at return-from-interrupt: one more instruction runs before the call.
// - worst response 18 cycles: detect, return, divide, long call.
// - no dispatch while a flash program or erase stalls the core.
// - equal or lower level waits for return plus one instruction.
// - converter done vectors to 0x007B, order 15, enable bit 1.
// - four software sources, orders 16 to 19, vectors 0x0083 to 0x009B.
// - order 20 has no source; crystal ready is order 21 at 0x00AB.
// - level-select bits 5..0 pick high level for the six basic sources.
// - enable bit7 crystal ready, bits 5..2 software 3..0, bit1 converter.
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH
`define LEVEL_SELECT_ADDR 8'hB8
`define SOURCE_ENABLE_TWO_ADDR 8'hE7
`define LEVEL_SELECT_RESET 8'h00
`define SOURCE_ENABLE_TWO_RESET 8'h00
`define LEVEL_SELECT_MASK 8'h3F
`define SOURCE_ENABLE_TWO_MASK 8'hBE
`define EN_CONVERTER_BIT 1
`define EN_SOFT0_BIT 2
`define EN_CRYSTAL_BIT 7
`define ORDER_CONVERTER 5'd15
`define ORDER_SOFT0 5'd16
`define ORDER_UNUSED 5'd20
`define ORDER_CRYSTAL 5'd21
`define NUM_SOURCES 22
`define NUM_BASIC_LEVELS 6
`define VECTOR_BASE 16'h0003
`define VECTOR_STRIDE_SHIFT 3
`define DETECT_CYCLES 1
`define LONG_CALL_CYCLES 4
`define RETURN_CYCLES 5
`define DIVIDE_CYCLES 8
`endif

/* File: rtl/intc_pkg.sv */
package intc_pkg;
    typedef logic [21:0] source_vec_type;
    typedef logic [4:0] order_type;
    typedef logic [15:0] vector_type;
    typedef enum logic [1:0] {
        st_run = 2'b00,
        st_after_return = 2'b01,
        st_flash_stall = 2'b10
    } dispatch_state_type;
endpackage

/* File: rtl/level_arbiter.sv */
`timescale 1ns/1ps
`include "intc_defines.svh"
module level_arbiter (
    input wire intc_pkg::source_vec_type requests,
    input wire intc_pkg::source_vec_type high_level,
    output logic winner_valid,
    output intc_pkg::order_type winner_order,
    output logic winner_high
);
    import intc_pkg::*;

    // lowest set bit wins, used once per level
    function automatic order_type first_set(input source_vec_type v);
        order_type r;
        r = 5'd0;
        for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = order_type'(i);
            end
        end
        return r;
    endfunction

    source_vec_type high_req;

    // high level first, fixed order inside a level
    always_comb begin
        high_req = requests & high_level;
        winner_valid = |requests;
        winner_high = |high_req;
        if (|high_req) begin
            winner_order = first_set(high_req);
        end else begin
            winner_order = first_set(requests);
        end
    end
endmodule

/* File: testbench/intc_properties.sv */
`timescale 1ns/1ps
module intc_properties (
    input wire logic clock,
    input wire logic nrst,
    input wire logic flash_busy,
    input wire logic reti_done,
    input wire logic instr_done,
    input wire logic irq_ack,
    input wire logic irq_request,
    input wire logic [15:0] irq_vector,
    input wire logic irq_high_level,
    input wire logic low_in_service,
    input wire logic high_in_service
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // gating of the offered request
    a_flash_no_dispatch: assert property (flash_busy |-> !irq_request)
        else $error("request during stall");
    a_high_no_preempt: assert property (high_in_service |-> !irq_request)
        else $error("high routine preempted");
    a_low_only_high: assert property (low_in_service && irq_request |-> irq_high_level)
        else $error("equal level offered");
    a_reti_blocks: assert property (reti_done |-> !irq_request)
        else $error("request on return");
    // the hold lasts until the following instruction retires
    a_hold_one_instr: assert property ((reti_done && !flash_busy) ##1 !(instr_done || flash_busy)
        |-> !irq_request) else $error("request before instruction");
    a_ack_marks: assert property (irq_ack && irq_request && !reti_done
        |=> ($past(irq_high_level) ? high_in_service : low_in_service)) else $error("service not marked");
    a_reti_high_first: assert property (reti_done && high_in_service
        |=> !high_in_service && low_in_service == $past(low_in_service)) else $error("bad high return");
    a_reti_clears_low: assert property (reti_done && !high_in_service |=> !low_in_service)
        else $error("low not cleared");
    a_vector_slot: assert property (irq_request
        |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h00AB && irq_vector != 16'h00A3)
        else $error("bad vector");
    c_preempt: cover property (low_in_service && irq_ack);
    c_nested_return: cover property (reti_done && high_in_service);
    c_stall: cover property (flash_busy ##1 !flash_busy ##1 irq_request);
endmodule
bind two_level_interrupt_priority intc_properties chk (.clock, .nrst, .flash_busy, .reti_done, .instr_done,
    .irq_ack, .irq_request, .irq_vector, .irq_high_level, .low_in_service, .high_in_service);

/* File: testbench/core_model.sv */
`timescale 1ns/1ps
module core_model #(parameter int HOLD = 3) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic irq_request,
    input wire logic auto_ack,
    input wire logic ret_cmd,
    output logic irq_ack,
    output logic reti_done,
    output logic instr_done
);
    logic [3:0] count_q;
    // long call taken at once while a winner is offered
    assign irq_ack = auto_ack & irq_request;
    // one instruction retires a few cycles after a return
    assign instr_done = (count_q == 4'h1);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reti_done <= 1'h0;
            count_q <= 4'h0;
        end else begin
            reti_done <= ret_cmd;
            if (reti_done)
                count_q <= 4'(HOLD);
            else if (count_q != 4'h0)
                count_q <= count_q - 4'h1;
        end
    end
endmodule

/* File: testbench/two_level_interrupt_priority_bench.sv */
`timescale 1ns/1ps
module two_level_interrupt_priority_bench;
    import intc_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rd;
        logic [14:0] basic;
        logic [5:0] pend;
        logic [15:0] upper;
        vector_type vec;
        logic hi;
    } row_type;
    // pend is crystal, soft 3..0, converter; vec zero means no request; hi is the winner's level
    row_type rows [13] = '{
        '{8'hB8, 8'hFF, 8'h3F, 15'h0000, 6'h00, 16'h0000, 16'h0000, 1'h0},
        '{8'hE7, 8'h02, 8'h02, 15'h0000, 6'h01, 16'h0000, 16'h007B, 1'h0},
        '{8'hE7, 8'h04, 8'h04, 15'h0000, 6'h02, 16'h0000, 16'h0083, 1'h0},
        '{8'hE7, 8'h3C, 8'h3C, 15'h0000, 6'h1F, 16'h0000, 16'h0083, 1'h0},
        '{8'hE7, 8'h20, 8'h20, 15'h0000, 6'h1F, 16'h0000, 16'h009B, 1'h0},
        '{8'hE7, 8'h80, 8'h80, 15'h0000, 6'h20, 16'h0000, 16'h00AB, 1'h0},
        '{8'hE7, 8'hBE, 8'hBE, 15'h0000, 6'h3F, 16'h0000, 16'h007B, 1'h0},
        '{8'hE7, 8'hBE, 8'hBE, 15'h0000, 6'h3F, 16'h8000, 16'h00AB, 1'h1},
        '{8'hE7, 8'hBE, 8'hBE, 15'h0000, 6'h3F, 16'h0400, 16'h0083, 1'h1},
        '{8'hE7, 8'hBE, 8'hBE, 15'h4000, 6'h3F, 16'h0000, 16'h0073, 1'h0},
        '{8'hE7, 8'hBE, 8'hBE, 15'h0001, 6'h3F, 16'h8000, 16'h0003, 1'h1},
        '{8'hE7, 8'h01, 8'h00, 15'h0000, 6'h3F, 16'h0000, 16'h0000, 1'h0},
        '{8'h55, 8'hFF, 8'h00, 15'h0000, 6'h3F, 16'h0000, 16'h0000, 1'h0}};
    logic clock, nrst, sfr_write, sfr_read, flash_busy, auto_ack, ret_cmd;
    logic irq_ack, reti_done, instr_done, irq_request, irq_high_level, low_in_service, high_in_service;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [14:0] basic_pending;
    logic [14:0] basic_enable;
    logic [15:0] upper;
    logic [5:0] pend;
    vector_type irq_vector;
    int err_count, check_count;
    two_level_interrupt_priority DUT (.clock, .nrst, .sfr_addr, .sfr_write, .sfr_read, .sfr_wdata, .sfr_rdata,
        .basic_pending, .basic_enable, .upper_level_select(upper), .converter_done_pending(pend[0]),
        .soft_pending(pend[4:1]), .crystal_valid_flag(pend[5]), .flash_busy, .instr_done, .reti_done, .irq_ack,
        .irq_request, .irq_vector, .irq_high_level, .low_in_service, .high_in_service);
    core_model #(.HOLD(3)) core (.clock, .nrst, .irq_request, .auto_ack, .ret_cmd, .irq_ack, .reti_done,
        .instr_done);
    always #5 clock = ~clock;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        if (seen !== exp)
            err_count++;
    endtask
    // one strobed byte; held across the sampling edge
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_write = w;
        sfr_read = !w;
        @(negedge clock);
        sfr_write = 1'h0;
        sfr_read = 1'h0;
        // idle cycle, so a following call never re-drives a strobe in the same step
        @(negedge clock);
    endtask
    task automatic ret();
        ret_cmd = 1'h1;
        @(negedge clock);
        ret_cmd = 1'h0;
        @(negedge clock);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // stuck run guard, far beyond the hundred or so cycles used
    initial begin
        #20000;
        err_count++;
        give_verdict();
    end
    initial begin
        {clock, sfr_write, sfr_read, flash_busy, auto_ack, ret_cmd} = 6'h00;
        {sfr_addr, sfr_wdata, basic_pending, upper, pend} = 53'h0;
        basic_enable = 15'h7FFF;
        nrst = 1'h0;
        repeat (5) @(negedge clock);
        nrst = 1'h1;
        foreach (rows[i]) begin
            basic_pending = rows[i].basic;
            pend = rows[i].pend;
            upper = rows[i].upper;
            access(rows[i].addr, rows[i].wdata, 1'h1);
            access(rows[i].addr, 8'h00, 1'h0);
            @(negedge clock);
            check(sfr_rdata, rows[i].rd);
            check({irq_request, irq_high_level}, {rows[i].vec != 16'h0000, rows[i].hi});
            if (rows[i].vec != 16'h0000)
                check(irq_vector, rows[i].vec);
        end
        // second reset with sources still pending
        nrst = 1'h0;
        @(negedge clock);
        nrst = 1'h1;
        access(8'hB8, 8'h00, 1'h0);
        check(sfr_rdata, 8'h00);
        access(8'hE7, 8'h00, 1'h0);
        check(sfr_rdata, 8'h00);
        check(irq_request, 1'h0);
        // low converter taken, then crystal at high level preempts it
        upper = 16'h8000;
        pend = 6'h01;
        auto_ack = 1'h1;
        access(8'hE7, 8'h82, 1'h1);
        repeat (3) @(negedge clock);
        check({low_in_service, high_in_service, irq_request}, 3'h4);
        pend = 6'h21;
        repeat (3) @(negedge clock);
        check({low_in_service, high_in_service, irq_request}, 3'h6);
        pend = 6'h01;
        ret();
        check({low_in_service, high_in_service}, 2'h2);
        repeat (4) @(negedge clock);
        auto_ack = 1'h0;
        ret();
        check({low_in_service, irq_request}, 2'h0);
        repeat (2) @(negedge clock);
        check({instr_done, irq_request}, 2'h2);
        repeat (2) @(negedge clock);
        check(irq_request, 1'h1);
        check(irq_vector, 16'h007B);
        // a flash stall withholds the pending request
        flash_busy = 1'h1;
        repeat (4) @(negedge clock);
        check(irq_request, 1'h0);
        flash_busy = 1'h0;
        repeat (2) @(negedge clock);
        check(irq_request, 1'h1);
        // one detect cycle, then the crystal source offered at high level
        pend = 6'h00;
        @(negedge clock);
        check(irq_request, 1'h0);
        pend = 6'h20;
        check(irq_request, 1'h0);
        @(negedge clock);
        check({irq_request, irq_high_level}, 2'h3);
        check(irq_vector, 16'h00AB);
        // basic enables mask their sources; level select was cleared by the reset
        pend = 6'h00;
        basic_pending = 15'h0001;
        basic_enable = 15'h0000;
        repeat (2) @(negedge clock);
        check(irq_request, 1'h0);
        basic_enable = 15'h7FFF;
        @(negedge clock);
        check({irq_request, irq_high_level}, 2'h2);
        check(irq_vector, 16'h0003);
        give_verdict();
    end
endmodule
